// ===== hdl/sram_ctrl_pkg.sv
// Purpose: shared constants and types of the burst sram control block
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes: register offsets are byte addresses on a 32-bit classic wishbone slave
package sram_ctrl_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int WB_ADR_W = 8;
  localparam int CLK_PERIOD_NS = 8;

  // register map
  localparam logic [WB_ADR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [WB_ADR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;

  // ctrl fields
  localparam int CTRL_FORCE_SLEEP_BIT = 0;

  // status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_WRITE_BIT = 2;
  localparam int STAT_INTERLEAVE_BIT = 3;
  localparam int STAT_ADDR_LSB = 4;

  typedef enum logic [1:0] {
    MODE_DESELECT = 2'b00,
    MODE_ACTIVE = 2'b01,
    MODE_SLEEP = 2'b10
  } mode_t;
endpackage

// ===== hdl/burst_seq.sv
// Purpose: low two address bits of a four-beat burst
// Assumes: count is the number of advances since the burst start
// Notes: combinational, no state
`timescale 1ns/100ps
module burst_seq (
  input wire logic [1:0] start_i,
  input wire logic [1:0] count_i,
  input wire logic interleaved_i,
  output logic [1:0] addr_o
);
  always_comb begin
    if (interleaved_i) begin
      addr_o = start_i ^ count_i;
    end else begin
      addr_o = 2'(start_i + count_i);
    end
  end
endmodule

// ===== hdl/sync_burst_sram_control.sv
// Purpose: control logic of a synchronous pipelined burst sram
// Assumes: the bus master runs on clk_i; the array is an external synchronous memory
// Notes: data bus enable follows output_enable_n_i and sleep_request_i without a clock
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module sync_burst_sram_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [sram_ctrl_pkg::ADDR_W-1:0] ext_addr_i,
  input wire logic primary_chip_enable_n_i,
  input wire logic depth_enable_high_i,
  input wire logic depth_enable_low_n_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  input wire logic global_write_n_i,
  input wire logic byte_write_enable_n_i,
  input wire logic [sram_ctrl_pkg::LANES-1:0] byte_lane_select_n_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_select_i,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] data_io_lanes_i,
  output logic [sram_ctrl_pkg::DATA_W-1:0] data_io_lanes_o,
  output logic data_io_lanes_oe_n_o,
  output logic array_en_o,
  output logic [sram_ctrl_pkg::LANES-1:0] array_we_o,
  output logic [sram_ctrl_pkg::ADDR_W-1:0] array_addr_o,
  output logic [sram_ctrl_pkg::DATA_W-1:0] array_wdata_o,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] array_rdata_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sram_ctrl_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] wb_dat_i,
  output logic [sram_ctrl_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o
);
  import sram_ctrl_pkg::*;

  typedef struct packed {
    mode_t mode;
    logic [ADDR_W-1:0] base;
    logic [1:0] count;
    logic wr;
    logic en;
    logic [LANES-1:0] we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rd_valid;
    logic [1:0] sleep_sync;
    logic [1:0] order_sync;
    logic [DATA_W-1:0] ctrl;
    logic ack;
    logic [DATA_W-1:0] wb_rdata;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  logic [1:0] burst_low;
  logic [1:0] next_count;
  logic [1:0] next_low;

  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [3:0] sel);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // burst address for the advanced count of the running burst
  assign next_count = 2'(cur_ff.count + 2'h1);

  burst_seq u_burst_seq (
    .start_i(cur_ff.base[1:0]),
    .count_i(next_count),
    .interleaved_i(cur_ff.order_sync[1]),
    .addr_o(next_low)
  );

  assign burst_low = next_low;

  always_comb begin
    logic selected;
    logic strobe;
    logic [LANES-1:0] lanes;
    logic asleep;
    logic wb_req;
    selected = 1'b0;
    strobe = 1'b0;
    lanes = '0;
    asleep = 1'b0;
    wb_req = wb_cyc_i & wb_stb_i;
    nxt_cur = cur_ff;

    nxt_cur.sleep_sync = {cur_ff.sleep_sync[0], sleep_request_i};
    nxt_cur.order_sync = {cur_ff.order_sync[0], burst_order_select_i};
    asleep = cur_ff.sleep_sync[1] | cur_ff.ctrl[CTRL_FORCE_SLEEP_BIT];

    selected = ~primary_chip_enable_n_i & depth_enable_high_i
               & ~depth_enable_low_n_i;

    if (~global_write_n_i) begin
      lanes = {LANES{1'b1}};
    end else if (~byte_write_enable_n_i) begin
      lanes = ~byte_lane_select_n_i;
    end

    nxt_cur.en = 1'b0;
    nxt_cur.we = '0;
    nxt_cur.rd_valid = 1'b0;

    if (~processor_addr_strobe_n_i & ~primary_chip_enable_n_i) begin
      strobe = 1'b1;
      nxt_cur.wr = 1'b0;
    end else if (~controller_addr_strobe_n_i) begin
      strobe = 1'b1;
      nxt_cur.wr = |lanes;
    end

    if (asleep) begin
      nxt_cur.mode = MODE_SLEEP;
    end else if (strobe) begin
      nxt_cur.count = 2'h0;
      if (selected) begin
        nxt_cur.mode = MODE_ACTIVE;
        nxt_cur.base = ext_addr_i;
        nxt_cur.addr = ext_addr_i;
      end else begin
        nxt_cur.mode = MODE_DESELECT;
      end
    end else if (cur_ff.mode == MODE_ACTIVE) begin
      nxt_cur.wr = |lanes;
      if (~burst_advance_n_i) begin
        nxt_cur.count = next_count;
        nxt_cur.addr = {cur_ff.base[ADDR_W-1:2], burst_low};
      end
    end

    case (nxt_cur.mode)
      MODE_ACTIVE: begin
        nxt_cur.en = 1'b1;
        if (nxt_cur.wr) begin
          nxt_cur.we = lanes;
          nxt_cur.wdata = data_io_lanes_i;
        end else begin
          nxt_cur.rd_valid = 1'b1;
        end
      end
      MODE_DESELECT: begin
        nxt_cur.en = 1'b0;
      end
      MODE_SLEEP: begin
        nxt_cur.en = 1'b0;
      end
      default: begin
        nxt_cur.mode = MODE_DESELECT;
      end
    endcase

    // read data flows out one cycle after the array access
    nxt_cur.rdata = cur_ff.rd_valid ? array_rdata_i : cur_ff.rdata;

    nxt_cur.ack = wb_req & ~cur_ff.ack;
    if (wb_req & ~cur_ff.ack) begin
      case (wb_adr_i)
        CTRL_OFFSET: begin
          nxt_cur.wb_rdata = cur_ff.ctrl;
        end
        STATUS_OFFSET: begin
          nxt_cur.wb_rdata = '0;
          nxt_cur.wb_rdata[STAT_MODE_LSB +: 2] = cur_ff.mode;
          nxt_cur.wb_rdata[STAT_WRITE_BIT] = cur_ff.wr;
          nxt_cur.wb_rdata[STAT_INTERLEAVE_BIT] = cur_ff.order_sync[1];
          nxt_cur.wb_rdata[STAT_ADDR_LSB +: ADDR_W] = cur_ff.addr;
        end
        default: begin
          nxt_cur.wb_rdata = '0;
        end
      endcase
    end
    if (wb_req & cur_ff.ack & wb_we_i & (wb_adr_i == CTRL_OFFSET)) begin
      nxt_cur.ctrl = lane_merge(cur_ff.ctrl, wb_dat_i, wb_sel_i) & 32'h00000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff <= '0;
      cur_ff.mode <= MODE_DESELECT;
      cur_ff.ctrl <= CTRL_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // bus drive is gated by output enable and sleep with no clock in the path
  always_comb begin
    data_io_lanes_oe_n_o = ~(cur_ff.rd_valid & ~output_enable_n_i
                             & ~sleep_request_i);
  end

  assign data_io_lanes_o = cur_ff.rdata;
  assign array_en_o = cur_ff.en;
  assign array_we_o = cur_ff.we;
  assign array_addr_o = cur_ff.addr;
  assign array_wdata_o = cur_ff.wdata;
  assign wb_dat_o = cur_ff.wb_rdata;
  assign wb_ack_o = cur_ff.ack;
endmodule

// ===== tb/sram_ctrl_props.sv
// Purpose: pin checks of the burst sram control
// Assumes: one clock, synchronous reset high
// Notes: bound into every control instance
`timescale 1ns/100ps
module sram_ctrl_props import sram_ctrl_pkg::*; (
  input wire logic clk_i, rst_i, primary_chip_enable_n_i, depth_enable_high_i,
  input wire logic depth_enable_low_n_i, processor_addr_strobe_n_i, controller_addr_strobe_n_i,
  input wire logic global_write_n_i, output_enable_n_i, sleep_request_i,
  input wire logic data_io_lanes_oe_n_o, array_en_o,
  input wire logic [LANES-1:0] array_we_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ctl;
    processor_addr_strobe_n_i && !controller_addr_strobe_n_i;
  endsequence
  sequence s_take;
    s_ctl ##0 (!primary_chip_enable_n_i && depth_enable_high_i && !depth_enable_low_n_i);
  endsequence
  AST_GWR: assert property (s_take ##0 !global_write_n_i |=> array_we_o == 4'hF)
    else $error("lane missed");
  AST_TAKE: assert property (s_take |=> array_en_o) else $error("no access");
  AST_DSEL1: assert property (s_ctl ##0 primary_chip_enable_n_i |=> !array_en_o)
    else $error("not deselected");
  AST_DSEL2: assert property (s_ctl ##0 !depth_enable_high_i |=> !array_en_o)
    else $error("not deselected");
  AST_DSEL3: assert property (s_ctl ##0 depth_enable_low_n_i |=> !array_en_o)
    else $error("not deselected");
  AST_OEZ: assert property (sleep_request_i || output_enable_n_i |-> data_io_lanes_oe_n_o)
    else $error("bus driven");
  AST_WRZ: assert property (array_we_o != 4'h0 |-> data_io_lanes_oe_n_o)
    else $error("bus driven on write");
  AST_RD: assert property (!processor_addr_strobe_n_i && !primary_chip_enable_n_i &&
    depth_enable_high_i && !depth_enable_low_n_i && !sleep_request_i ##1
    (!output_enable_n_i && !sleep_request_i) |-> !data_io_lanes_oe_n_o) else $error("no drive");
endmodule
bind sync_burst_sram_control sram_ctrl_props i_sram_ctrl_props (.*);

// ===== tb/sram_array_model.sv
// Purpose: external array behind the control block
// Assumes: combinational read of the addressed word
// Notes: 16 words; an idle read shows inverted data
`timescale 1ns/100ps
module sram_array_model import sram_ctrl_pkg::*; (
  input wire logic clk_i, en_i,
  input wire logic [LANES-1:0] we_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem_ff [16];
  assign rdata_o = en_i ? mem_ff[addr_i[3:0]] : ~mem_ff[addr_i[3:0]];
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < LANES; i++) begin
      if (en_i && we_i[i]) mem_ff[addr_i[3:0]][8*i+:8] <= wdata_i[8*i+:8];
    end
  end
endmodule

// ===== tb/test_sync_burst_sram_control.sv
// Purpose: self-checking bench of the burst sram control
// Assumes: 125 MHz clock, array model on the far side
// Notes: strobe table, then burst, read, sleep and register tests
`timescale 1ns/100ps
module test_sync_burst_sram_control;
  import sram_ctrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, pn = 1'b1, cn = 1'b1, e1 = 1'b0, e2 = 1'b1, e3 = 1'b0;
  logic gw = 1'b1, bw = 1'b1, burst_advance_n = 1'b1, oe = 1'b1, zz = 1'b0, burst_order_select = 1'b0, cyc = 1'b0;
  logic stb = 1'b0, we = 1'b0, ack, dqoe, aen;
  logic [1:0] x;
  logic [3:0] sel = 4'hF, awe;
  logic [7:0] wa = 8'h00;
  logic [ADDR_W-1:0] addr = '0, aadr;
  logic [DATA_W-1:0] din = 32'hA5C31E0F, wd = '0, dq, awd, rd, wdo;
  logic [15:0] rows [9] = '{16'h57F0, 16'hB7E0, 16'h93FF, 16'h95D1, 16'h94BA, 16'h95F0,
    16'h87E0, 16'h9FE0, 16'h90DF};
  int miscompares = 0, n_checks = 0;
  always #4 clk = ~clk;
  sync_burst_sram_control i_sync_burst_sram_control (.clk_i(clk), .rst_i(rst), .ext_addr_i(addr),
    .primary_chip_enable_n_i(e1), .depth_enable_high_i(e2), .depth_enable_low_n_i(e3),
    .processor_addr_strobe_n_i(pn), .controller_addr_strobe_n_i(cn), .burst_advance_n_i(burst_advance_n),
    .global_write_n_i(gw), .byte_write_enable_n_i(bw), .byte_lane_select_n_i(sel),
    .output_enable_n_i(oe), .sleep_request_i(zz), .burst_order_select_i(burst_order_select),
    .data_io_lanes_i(din), .data_io_lanes_o(dq), .data_io_lanes_oe_n_o(dqoe), .array_en_o(aen),
    .array_we_o(awe), .array_addr_o(aadr), .array_wdata_o(awd), .array_rdata_i(rd),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(wa), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(wdo), .wb_ack_o(ack));
  sram_array_model i_sram_array_model (.clk_i(clk), .en_i(aen), .we_i(awe), .addr_i(aadr),
    .wdata_i(awd), .rdata_o(rd));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one strobe cycle with all enables valid; p low reads, else g picks write
  task automatic acc(input logic p, input logic g, input logic [ADDR_W-1:0] a);
    @(posedge clk);
    {pn, cn, gw, e1, e2, e3} <= {p, ~p, g, 3'b010};
    addr <= a;
    @(posedge clk);
    {pn, cn, gw} <= 3'b111;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    int k;
    @(posedge clk);
    {cyc, stb, we, wa, wd} <= {2'b11, w, a, d};
    k = 0;
    // look between edges so the registered ack and data are settled
    do begin
      @(negedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    if (!w) chk("wb", e, wdo);
    @(posedge clk);
    {cyc, stb} <= 2'b00;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      {pn, cn, e1, e2, e3, gw, bw, sel} <= rows[i][15:5];
      addr <= ADDR_W'(i + 8);
      @(posedge clk);
      {pn, cn, gw, bw} <= 4'hF;
      #1;
      chk("en", rows[i][4], aen);
      chk("we", rows[i][3:0], awe);
      if (rows[i][4]) chk("adr", i + 8, aadr);
    end
    $display("table test done");
    for (int m = 0; m < 2; m++) begin
      burst_order_select <= m[0];
      repeat (3) @(posedge clk);
      acc(1'b1, 1'b0, ADDR_W'(5));
      burst_advance_n <= 1'b0;
      for (int n = 1; n < 5; n++) begin
        @(posedge clk);
        if (n == 3) burst_advance_n <= 1'b1;
        #1;
        if (n < 4) x = m ? 2'h1 ^ n[1:0] : 2'h1 + n[1:0];
        chk("bur", x, aadr[1:0]);
      end
    end
    $display("burst test done");
    acc(1'b0, 1'b1, ADDR_W'(5));
    oe <= 1'b0;
    @(posedge clk);
    #1;
    chk("rdd", din, dq);
    chk("drv", 1'b0, dqoe);
    @(posedge clk);
    oe <= 1'b1;
    #1;
    chk("oe", 1'b1, dqoe);
    @(posedge clk);
    {oe, zz} <= 2'b01;
    #1;
    chk("zz", 1'b1, dqoe);
    repeat (4) @(posedge clk);
    zz <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("idle", 1'b0, aen);
    acc(1'b0, 1'b1, ADDR_W'(5));
    @(posedge clk);
    #1;
    chk("kep", din, dq);
    $display("read sleep test done");
    wb(1'b0, CTRL_OFFSET, 32'h0, CTRL_RESET);
    wb(1'b1, CTRL_OFFSET, 32'h1, 32'h0);
    wb(1'b0, CTRL_OFFSET, 32'h0, 32'h1);
    wb(1'b1, CTRL_OFFSET, 32'h0, 32'h0);
    wb(1'b0, 8'h08, 32'h0, 32'h0);
    $display("register test done");
    end_sim();
  end
endmodule
